// *** rtl/sim_cfg.svh ***
// What this block does
// - reverse limit open raises fault fourteen
// - forward limit open raises fault fifteen
// - torque caps need enable, position/speed only
// - speed select picks analog/zero or preset
// - torque select picks analog/zero or preset
// - each pin has its own function code
// - input function codes one through twenty-six
// - factory defaults for input pins one-six
// - output function codes and output defaults
// - each pin active level is configurable
// - emergency stop open raises fault thirteen
// - speed/position switch: off speed, on position
// - function code zero leaves pin unused
`ifndef SIM_CFG_SVH
`define SIM_CFG_SVH

// ****************
// register map
// ****************
`define SIM_ADDR_W 4
`define SIM_REG_DI_BASE 4'h0
`define SIM_REG_DO_BASE 4'h6
`define SIM_REG_POL 4'h9
`define SIM_REG_CTRL 4'ha
`define SIM_REG_STATUS 4'hb
`define SIM_REG_MASK 4'hc
`define SIM_REG_LEVELS 4'hd

// ****************
// input function codes
// ****************
`define SIM_FN_NONE 5'h00
`define SIM_FN_SERVO_ON 5'h01
`define SIM_FN_ALARM_RESET 5'h02
`define SIM_FN_GAIN 5'h03
`define SIM_FN_PULSE_CLEAR 5'h04
`define SIM_FN_ZERO_CLAMP 5'h05
`define SIM_FN_CMD_REV 5'h06
`define SIM_FN_PULSE_INH 5'h07
`define SIM_FN_TORQUE_CAP_EN 5'h09
`define SIM_FN_SPEED_CAP_EN 5'h0a
`define SIM_FN_GEAR 5'h0b
`define SIM_FN_SPEED_LO 5'h0e
`define SIM_FN_SPEED_HI 5'h0f
`define SIM_FN_TORQUE_LO 5'h10
`define SIM_FN_TORQUE_HI 5'h11
`define SIM_FN_SW_SP 5'h12
`define SIM_FN_SW_ST 5'h13
`define SIM_FN_SW_TP 5'h14
`define SIM_FN_ESTOP 5'h15
`define SIM_FN_REV_LIMIT 5'h16
`define SIM_FN_FWD_LIMIT 5'h17
`define SIM_FN_REV_TCAP 5'h19
`define SIM_FN_FWD_TCAP 5'h1a

// ****************
// output function codes (brake kept as printed, 80)
// ****************
`define SIM_DO_READY 7'h01
`define SIM_DO_SERVO_ON 7'h02
`define SIM_DO_ZERO_SPEED 7'h03
`define SIM_DO_SPEED_REACHED 7'h04
`define SIM_DO_POS_DONE 7'h05
`define SIM_DO_TORQUE_REACHED 7'h06
`define SIM_DO_ALARM 7'h07
`define SIM_DO_BRAKE 7'h50
`define SIM_DO_OVERLOAD 7'h09
`define SIM_DO_WARNING 7'h0a

// ****************
// fault numbers, status bits, field positions
// ****************
`define SIM_FAULT_ESTOP 8'h0d
`define SIM_FAULT_REV 8'h0e
`define SIM_FAULT_FWD 8'h0f
`define SIM_FAULT_NONE 8'h00
`define SIM_ST_ESTOP 0
`define SIM_ST_REV 1
`define SIM_ST_FWD 2
`define SIM_CTRL_TCAP_EN 0
`define SIM_CTRL_ZERO_MODE 1
`define SIM_NUM_DI 6
`define SIM_NUM_DO 3
`endif

// *** rtl/sim_pkg.sv ***
package sim_pkg;
    // source of a speed or torque command
    typedef enum logic [1:0]
    {
        SIM_SRC_ANALOG = 2'b00,
        SIM_SRC_PRESET1 = 2'b01,
        SIM_SRC_PRESET2 = 2'b10,
        SIM_SRC_PRESET3 = 2'b11
    } sim_src_t;
    // operating mode
    typedef enum logic [1:0]
    {
        SIM_MODE_SPEED = 2'b00,
        SIM_MODE_POSITION = 2'b01,
        SIM_MODE_TORQUE = 2'b10
    } sim_mode_t;
endpackage : sim_pkg

// *** rtl/sim_mapper.sv ***
`timescale 1ns/100ps
`include "sim_cfg.svh"

module sim_mapper
(
    input wire logic clk_sys_in,
    input wire logic alarm_reset_in_n_in,
    input wire logic [`SIM_ADDR_W-1:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    input wire logic [`SIM_NUM_DI-1:0] di_pin_in,
    output logic [`SIM_NUM_DO-1:0] do_pin_out,
    input wire logic ready_in,
    input wire logic servo_active_in,
    input wire logic zero_speed_in,
    input wire logic speed_reached_in,
    input wire logic position_done_in,
    input wire logic torque_reached_in,
    input wire logic alarm_in,
    input wire logic brake_in,
    input wire logic overload_in,
    input wire logic warning_in,
    output logic servo_on_out,
    output logic alarm_reset_out,
    output logic gain_switch_out,
    output logic pulse_clear_out,
    output logic zero_clamp_out,
    output logic command_reverse_out,
    output logic pulse_inhibit_out,
    output logic torque_cap_enable_out,
    output logic speed_cap_enable_out,
    output logic gear_select_out,
    output sim_pkg::sim_src_t speed_source_out,
    output logic speed_zero_out,
    output sim_pkg::sim_src_t torque_source_out,
    output logic torque_zero_out,
    output sim_pkg::sim_mode_t mode_out,
    output logic reverse_torque_cap_out,
    output logic forward_torque_cap_out,
    output logic [7:0] fault_code_out,
    output logic irq_out
);
    import sim_pkg::*;

    // ****************
    // configuration registers
    // ****************
    logic [4:0] di_fn [`SIM_NUM_DI]; // function code per input pin
    logic [6:0] do_fn [`SIM_NUM_DO]; // function code per output pin
    logic [8:0] pol; // bit set inverts the pin, di low six
    logic [1:0] ctrl; // torque cap enable, zero-command mode
    logic [2:0] status; // sticky fault events
    logic [2:0] mask; // interrupt enables
    logic [31:0] rdata;

    // ****************
    // input synchroniser and polarity
    // ****************
    logic [`SIM_NUM_DI-1:0] sync1; // first stage, read only by sync2
    logic [`SIM_NUM_DI-1:0] sync2;
    logic [`SIM_NUM_DI-1:0] di_lvl; // after polarity correction

    // two flops guard against metastable pin levels
    always_ff @(posedge clk_sys_in or negedge alarm_reset_in_n_in)
    begin
        if (!alarm_reset_in_n_in)
        begin
            sync1 <= 6'h00;
            sync2 <= 6'h00;
        end
        else
        begin
            sync1 <= di_pin_in;
            sync2 <= sync1;
        end
    end

    assign di_lvl = sync2 ^ pol[5:0];

    // ****************
    // function decode: a function is on if any pin carrying it is on
    // ****************
    logic [31:0] fn_on; // indexed by input function code
    logic [31:0] fn_mapped; // function assigned to some pin
    logic [31:0] pin_hot [`SIM_NUM_DI];
    logic [31:0] pin_map [`SIM_NUM_DI];

    genvar gi;
    generate
        for (gi = 0; gi < `SIM_NUM_DI; gi++)
        begin : g_di
            // code zero lands on bit 0, which nothing reads
            assign pin_map[gi] = 32'h1 << di_fn[gi];
            assign pin_hot[gi] = di_lvl[gi] ? pin_map[gi] : 32'h0;
        end
    endgenerate

    // or-reduce the per-pin one-hot maps
    always_comb
    begin
        fn_on = 32'h0;
        fn_mapped = 32'h0;
        for (int i = 0; i < `SIM_NUM_DI; i++)
        begin
            fn_on = fn_on | pin_hot[i];
            fn_mapped = fn_mapped | pin_map[i];
        end
    end

    // ****************
    // decoded functions
    // ****************
    wire logic mode_sp = fn_on[`SIM_FN_SW_SP];
    wire logic mode_st = fn_on[`SIM_FN_SW_ST];
    wire logic mode_tp = fn_on[`SIM_FN_SW_TP];
    wire logic [1:0] spd_code = {fn_on[`SIM_FN_SPEED_HI], fn_on[`SIM_FN_SPEED_LO]};
    wire logic [1:0] trq_code = {fn_on[`SIM_FN_TORQUE_HI], fn_on[`SIM_FN_TORQUE_LO]};
    // normally-closed contacts: a mapped contact reading off is a fault
    wire logic estop_open = fn_mapped[`SIM_FN_ESTOP] & ~fn_on[`SIM_FN_ESTOP];
    wire logic rev_open = fn_mapped[`SIM_FN_REV_LIMIT] & ~fn_on[`SIM_FN_REV_LIMIT];
    wire logic fwd_open = fn_mapped[`SIM_FN_FWD_LIMIT] & ~fn_on[`SIM_FN_FWD_LIMIT];
    sim_mode_t next_mode;

    // mode switches; speed/position wins when several are mapped
    always_comb
    begin
        if (fn_mapped[`SIM_FN_SW_SP])
            next_mode = mode_sp ? SIM_MODE_POSITION : SIM_MODE_SPEED;
        else if (fn_mapped[`SIM_FN_SW_ST])
            next_mode = mode_st ? SIM_MODE_TORQUE : SIM_MODE_SPEED;
        else if (fn_mapped[`SIM_FN_SW_TP])
            next_mode = mode_tp ? SIM_MODE_POSITION : SIM_MODE_TORQUE;
        else
            next_mode = SIM_MODE_SPEED;
    end

    // caps only valid outside torque mode and with enable set
    wire logic tcap_ok = ctrl[`SIM_CTRL_TCAP_EN] & (next_mode != SIM_MODE_TORQUE);

    // ****************
    // decoded outputs, registered
    // ****************
    always_ff @(posedge clk_sys_in or negedge alarm_reset_in_n_in)
    begin
        if (!alarm_reset_in_n_in)
        begin
            servo_on_out <= 1'b0;
            alarm_reset_out <= 1'b0;
            gain_switch_out <= 1'b0;
            pulse_clear_out <= 1'b0;
            zero_clamp_out <= 1'b0;
            command_reverse_out <= 1'b0;
            pulse_inhibit_out <= 1'b0;
            torque_cap_enable_out <= 1'b0;
            speed_cap_enable_out <= 1'b0;
            gear_select_out <= 1'b0;
            speed_source_out <= SIM_SRC_ANALOG;
            speed_zero_out <= 1'b0;
            torque_source_out <= SIM_SRC_ANALOG;
            torque_zero_out <= 1'b0;
            mode_out <= SIM_MODE_SPEED;
            reverse_torque_cap_out <= 1'b0;
            forward_torque_cap_out <= 1'b0;
        end
        else
        begin
            servo_on_out <= fn_on[`SIM_FN_SERVO_ON];
            alarm_reset_out <= fn_on[`SIM_FN_ALARM_RESET];
            gain_switch_out <= fn_on[`SIM_FN_GAIN];
            pulse_clear_out <= fn_on[`SIM_FN_PULSE_CLEAR];
            zero_clamp_out <= fn_on[`SIM_FN_ZERO_CLAMP];
            command_reverse_out <= fn_on[`SIM_FN_CMD_REV];
            pulse_inhibit_out <= fn_on[`SIM_FN_PULSE_INH];
            torque_cap_enable_out <= fn_on[`SIM_FN_TORQUE_CAP_EN];
            speed_cap_enable_out <= fn_on[`SIM_FN_SPEED_CAP_EN];
            gear_select_out <= fn_on[`SIM_FN_GEAR];
            speed_source_out <= sim_src_t'(spd_code);
            // zero rather than analog when both off in the z variant
            speed_zero_out <= (spd_code == 2'b00) & ctrl[`SIM_CTRL_ZERO_MODE];
            torque_source_out <= sim_src_t'(trq_code);
            torque_zero_out <= (trq_code == 2'b00) & ctrl[`SIM_CTRL_ZERO_MODE];
            mode_out <= next_mode;
            reverse_torque_cap_out <= fn_on[`SIM_FN_REV_TCAP] & tcap_ok;
            forward_torque_cap_out <= fn_on[`SIM_FN_FWD_TCAP] & tcap_ok;
        end
    end

    // ****************
    // fault code: estop outranks the travel limits
    // ****************
    wire logic [7:0] next_fault = estop_open ? `SIM_FAULT_ESTOP :
                                  rev_open ? `SIM_FAULT_REV :
                                  fwd_open ? `SIM_FAULT_FWD : `SIM_FAULT_NONE;

    // level fault, held while the contact is open
    always_ff @(posedge clk_sys_in or negedge alarm_reset_in_n_in)
    begin
        if (!alarm_reset_in_n_in)
            fault_code_out <= `SIM_FAULT_NONE;
        else
            fault_code_out <= next_fault;
    end

    // ****************
    // output pin mapping
    // ****************
    logic [`SIM_NUM_DO-1:0] do_raw;
    generate
        for (gi = 0; gi < `SIM_NUM_DO; gi++)
        begin : g_do
            // code zero and unknown codes drive inactive
            always_comb
            begin
                case (do_fn[gi])
                    `SIM_DO_READY: do_raw[gi] = ready_in;
                    `SIM_DO_SERVO_ON: do_raw[gi] = servo_active_in;
                    `SIM_DO_ZERO_SPEED: do_raw[gi] = zero_speed_in;
                    `SIM_DO_SPEED_REACHED: do_raw[gi] = speed_reached_in;
                    `SIM_DO_POS_DONE: do_raw[gi] = position_done_in;
                    `SIM_DO_TORQUE_REACHED: do_raw[gi] = torque_reached_in;
                    `SIM_DO_ALARM: do_raw[gi] = alarm_in;
                    `SIM_DO_BRAKE: do_raw[gi] = brake_in;
                    `SIM_DO_OVERLOAD: do_raw[gi] = overload_in;
                    `SIM_DO_WARNING: do_raw[gi] = warning_in;
                    default: do_raw[gi] = 1'b0;
                endcase
            end
        end
    endgenerate

    // registered so the pins never glitch during a remap
    always_ff @(posedge clk_sys_in or negedge alarm_reset_in_n_in)
    begin
        if (!alarm_reset_in_n_in)
            do_pin_out <= 3'h0;
        else
            do_pin_out <= do_raw ^ pol[8:6];
    end

    // ****************
    // register bus
    // ****************
    wire logic wr_ctrl = wr_in & (addr_in == `SIM_REG_CTRL);
    wire logic wr_pol = wr_in & (addr_in == `SIM_REG_POL);
    wire logic wr_mask = wr_in & (addr_in == `SIM_REG_MASK);
    wire logic rd_status = rd_in & (addr_in == `SIM_REG_STATUS);
    wire logic [2:0] events = {fwd_open, rev_open, estop_open};

    // per-pin code registers with factory defaults
    generate
        for (gi = 0; gi < `SIM_NUM_DI; gi++)
        begin : g_dicfg
            localparam logic [4:0] DEF = (gi == 0) ? `SIM_FN_SERVO_ON :
                                         (gi == 1) ? `SIM_FN_ALARM_RESET :
                                         (gi == 2) ? `SIM_FN_PULSE_CLEAR :
                                         (gi == 3) ? `SIM_FN_REV_LIMIT :
                                         (gi == 4) ? `SIM_FN_FWD_LIMIT : `SIM_FN_ESTOP;
            wire logic hit = wr_in & (addr_in == `SIM_REG_DI_BASE + 4'(gi));
            always_ff @(posedge clk_sys_in or negedge alarm_reset_in_n_in)
            begin
                if (!alarm_reset_in_n_in)
                    di_fn[gi] <= DEF;
                else if (hit)
                    di_fn[gi] <= wdata_in[4:0];
            end
        end
        for (gi = 0; gi < `SIM_NUM_DO; gi++)
        begin : g_docfg
            localparam logic [6:0] DEF = (gi == 0) ? `SIM_DO_READY :
                                         (gi == 1) ? `SIM_DO_SERVO_ON : `SIM_DO_ZERO_SPEED;
            wire logic hit = wr_in & (addr_in == `SIM_REG_DO_BASE + 4'(gi));
            always_ff @(posedge clk_sys_in or negedge alarm_reset_in_n_in)
            begin
                if (!alarm_reset_in_n_in)
                    do_fn[gi] <= DEF;
                else if (hit)
                    do_fn[gi] <= wdata_in[6:0];
            end
        end
    endgenerate

    // control, polarity, mask, sticky status
    always_ff @(posedge clk_sys_in or negedge alarm_reset_in_n_in)
    begin
        if (!alarm_reset_in_n_in)
        begin
            ctrl <= 2'h0;
            pol <= 9'h000;
            mask <= 3'h0;
            status <= 3'h0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl <= wdata_in[1:0];
            if (wr_pol)
                pol <= wdata_in[8:0];
            if (wr_mask)
                mask <= wdata_in[2:0];
            // a new event wins over the read that clears
            status <= (rd_status ? 3'h0 : status) | events;
        end
    end

    // ****************
    // read path, data in the cycle after the strobe
    // ****************
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0;
        if (addr_in < `SIM_REG_DO_BASE)
            rd_mux = {27'h0, di_fn[addr_in[2:0]]};
        else if (addr_in < `SIM_REG_POL)
            rd_mux = {25'h0, do_fn[2'(addr_in - `SIM_REG_DO_BASE)]};
        else
        begin
            case (addr_in)
                `SIM_REG_POL: rd_mux = {23'h0, pol};
                `SIM_REG_CTRL: rd_mux = {30'h0, ctrl};
                `SIM_REG_STATUS: rd_mux = {29'h0, status};
                `SIM_REG_MASK: rd_mux = {29'h0, mask};
                `SIM_REG_LEVELS: rd_mux = {23'h0, do_pin_out, di_lvl};
                default: rd_mux = 32'h0;
            endcase
        end
    end

    // unread cycles drop back to zero
    always_ff @(posedge clk_sys_in or negedge alarm_reset_in_n_in)
    begin
        if (!alarm_reset_in_n_in)
            rdata <= 32'h0;
        else
            rdata <= rd_in ? rd_mux : 32'h0;
    end

    assign rdata_out = rdata;
    assign irq_out = |(status & mask);

endmodule : sim_mapper

// *** dv/sim_ctl_model.sv ***
`timescale 1ns/100ps
// ****************
// controller side: drives the discrete input pins
// ****************
module sim_ctl_model
(
    input wire logic clk_sys_in,
    input wire logic [2:0] level_in, // levels for free pins one to three
    input wire logic [2:0] open_in, // contacts to open: stop, forward, reverse
    output logic [5:0] di_pin_out // pin levels seen by the device
);
    // contacts stay closed unless the bench opens one; updates only after an edge
    always_ff @(posedge clk_sys_in)
    begin
        di_pin_out <= {~open_in, level_in};
    end
endmodule : sim_ctl_model

// *** dv/sim_mapper_chk.sv ***
`timescale 1ns/100ps
`include "sim_cfg.svh"
// ****************
// port checker for the mapper
// ****************
module sim_mapper_chk
(
    input wire logic clk_sys_in,
    input wire logic alarm_reset_in_n_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic [`SIM_NUM_DI-1:0] di_pin_in,
    input wire logic [`SIM_NUM_DO-1:0] do_pin_out,
    input wire logic ready_in,
    input wire logic servo_active_in,
    input wire logic zero_speed_in,
    input wire logic speed_reached_in,
    input wire logic position_done_in,
    input wire logic torque_reached_in,
    input wire logic alarm_in,
    input wire logic brake_in,
    input wire logic overload_in,
    input wire logic warning_in,
    input wire logic servo_on_out,
    input wire sim_pkg::sim_src_t speed_source_out,
    input wire logic speed_zero_out,
    input wire sim_pkg::sim_src_t torque_source_out,
    input wire logic torque_zero_out,
    input wire sim_pkg::sim_mode_t mode_out,
    input wire logic reverse_torque_cap_out,
    input wire logic forward_torque_cap_out,
    input wire logic [7:0] fault_code_out,
    input wire logic irq_out
);
    import sim_pkg::*;
    // device states behind the output codes
    wire logic [9:0] dev_state = {warning_in, overload_in, brake_in, alarm_in, torque_reached_in,
        position_done_in, speed_reached_in, zero_speed_in, servo_active_in, ready_in};
    logic [2:0] since_rst; // edges since reset, saturating; hides the start-up jump
    // ****************
    // helper logic
    // ****************
    always_ff @(posedge clk_sys_in or negedge alarm_reset_in_n_in)
    begin
        if (!alarm_reset_in_n_in)
            since_rst <= 3'h0;
        else if (since_rst != 3'h7)
            since_rst <= since_rst + 3'h1;
    end
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!alarm_reset_in_n_in);
    // ****************
    // assertions
    // ****************
    AST_FAULT_SET: assert property (fault_code_out inside {8'h00, 8'h0d, 8'h0e, 8'h0f})
        else $error("fault code outside the defined set");
    AST_PIN_SYNC_DELAY: assert property ((since_rst == 3'h7) && $changed({servo_on_out, fault_code_out,
        mode_out, speed_source_out}) |-> ($past(di_pin_in, 3) != $past(di_pin_in, 4)) || $past(wr_in)
        || $past(wr_in, 2) || $past(wr_in, 3) || $past(wr_in, 4))
        else $error("decoded output moved without a pin change three edges before");
    AST_DO_FOLLOWS: assert property ((since_rst == 3'h7) && $changed(do_pin_out) |->
        ($past(dev_state) != $past(dev_state, 2)) || $past(wr_in) || $past(wr_in, 2) || $past(wr_in, 3))
        else $error("output pin moved without a cause");
    AST_RDATA_IDLE: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
        else $error("read data not zero outside a read");
    AST_TCAP_NOT_TORQUE: assert property (mode_out == SIM_MODE_TORQUE |-> !reverse_torque_cap_out && !forward_torque_cap_out)
        else $error("torque cap active in torque mode");
    AST_SPEED_ZERO_SRC: assert property (speed_zero_out |-> speed_source_out == SIM_SRC_ANALOG)
        else $error("zero speed command with a preset selected");
    AST_TORQUE_ZERO_SRC: assert property (torque_zero_out |-> torque_source_out == SIM_SRC_ANALOG)
        else $error("zero torque command with a preset selected");
    AST_MODE_LEGAL: assert property (mode_out != 2'h3)
        else $error("undefined mode");
    // main scenarios reached
    cover property (fault_code_out == 8'h0d);
    cover property (irq_out);
    cover property (mode_out == SIM_MODE_TORQUE);
endmodule : sim_mapper_chk
bind sim_mapper sim_mapper_chk sim_mapper_chk_inst (.*);

// *** dv/test_servo_input_function_mapper.sv ***
`timescale 1ns/100ps
`include "sim_cfg.svh"
// ****************
// bench for the input function mapper
// ****************
module test_servo_input_function_mapper;
    import sim_pkg::*;
    logic clk = 1'b0; // 50 MHz system clock
    logic rst_n = 1'b0; // async reset, low active
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [2:0] lvl = 3'h0; // free pin levels
    logic [2:0] opn = 3'h0; // contacts opened by the controller
    logic [9:0] dev = 10'h0; // device states behind output codes
    logic [31:0] rnd = 32'h00016900; // fixed seed
    logic [31:0] d;
    logic zm;
    wire logic [31:0] rdata;
    wire logic [5:0] di_pin;
    wire logic [2:0] do_pin;
    wire logic [9:0] fo; // decoded inputs in code table order
    wire sim_src_t spd_src;
    wire sim_src_t trq_src;
    wire sim_mode_t mode;
    wire logic spd_zero;
    wire logic trq_zero;
    wire logic rcap, fcap;
    wire logic irq;
    wire logic [7:0] fault;
    int errors = 0;
    int checked = 0;
    int cycles = 0;
    int i, p, k, j;
    int sel [3];
    logic [4:0] fn_code [10] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h09, 5'h0a, 5'h0b};
    logic [6:0] do_code [10] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07, 7'h50, 7'h09, 7'h0a};
    logic [4:0] di_def [6] = '{5'h01, 5'h02, 5'h04, 5'h16, 5'h17, 5'h15};
    logic [2:0] open_tab [4] = '{3'h0, 3'h4, 3'h1, 3'h2};
    sim_mapper sim_mapper_inst
    (
        .clk_sys_in(clk), .alarm_reset_in_n_in(rst_n), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
        .rdata_out(rdata), .di_pin_in(di_pin), .do_pin_out(do_pin), .ready_in(dev[0]), .servo_active_in(dev[1]),
        .zero_speed_in(dev[2]), .speed_reached_in(dev[3]), .position_done_in(dev[4]),
        .torque_reached_in(dev[5]), .alarm_in(dev[6]), .brake_in(dev[7]), .overload_in(dev[8]),
        .warning_in(dev[9]), .servo_on_out(fo[0]), .alarm_reset_out(fo[1]), .gain_switch_out(fo[2]),
        .pulse_clear_out(fo[3]), .zero_clamp_out(fo[4]), .command_reverse_out(fo[5]),
        .pulse_inhibit_out(fo[6]), .torque_cap_enable_out(fo[7]), .speed_cap_enable_out(fo[8]),
        .gear_select_out(fo[9]), .speed_source_out(spd_src), .speed_zero_out(spd_zero),
        .torque_source_out(trq_src), .torque_zero_out(trq_zero), .mode_out(mode),
        .reverse_torque_cap_out(rcap), .forward_torque_cap_out(fcap), .fault_code_out(fault), .irq_out(irq)
    );
    sim_ctl_model sim_ctl_model_inst (.clk_sys_in(clk), .level_in(lvl), .open_in(opn), .di_pin_out(di_pin));
    // ****************
    // helpers
    // ****************
    always #10 clk = ~clk;
    // hang guard, far above the expected run of under nine hundred cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            end_of_test();
        end
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    // fault number for one opened contact
    function automatic logic [7:0] fault_exp(input logic [2:0] o);
        case (o)
            3'h4: return 8'h0d;
            3'h1: return 8'h0e;
            3'h2: return 8'h0f;
            default: return 8'h00;
        endcase
    endfunction : fault_exp
    // zero command only with both selects off in zero mode
    function automatic logic src_zero(input logic [1:0] s, input logic z);
        return (s == 2'h0) && z;
    endfunction : src_zero
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask : bus_rd
    // pin path is three edges; five leaves margin after a write
    task automatic settle();
        repeat (5) @(posedge clk);
        #1;
    endtask : settle
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test
    // ****************
    // main sequence
    // ****************
    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 6; i++)
        begin
            bus_rd(4'(i), d);
            chk("input code", {27'h0, di_def[i]}, d);
        end
        for (i = 0; i < 3; i++)
        begin
            bus_rd(4'(6 + i), d);
            chk("output code", {25'h0, do_code[i]}, d);
        end
        bus_wr(4'hf, 32'hffffffff);
        bus_rd(4'hf, d);
        chk("unmapped index", 32'h0, d);
        bus_wr(`SIM_REG_MASK, 32'h7);
        for (i = 0; i < 4; i++)
        begin
            @(posedge clk);
            opn <= open_tab[i];
            settle();
            chk("fault code", {24'h0, fault_exp(open_tab[i])}, {24'h0, fault});
        end
        chk("irq raised", 32'h1, {31'h0, irq});
        bus_rd(`SIM_REG_STATUS, d);
        chk("status forward bit", 32'h1, {31'h0, d[2]});
        bus_wr(`SIM_REG_MASK, 32'h0);
        #1;
        chk("irq masked", 32'h0, {31'h0, irq});
        @(posedge clk);
        opn <= 3'h0;
        settle();
        bus_rd(`SIM_REG_STATUS, d);
        bus_rd(`SIM_REG_STATUS, d);
        chk("status cleared", 32'h0, d);
        bus_wr(`SIM_REG_MASK, 32'h7);
        #1;
        chk("irq after clear", 32'h0, {31'h0, irq});
        // random single-function mapping on the free pins, others left unused
        for (i = 0; i < 24; i++)
        begin
            rnd = lfsr_next(rnd);
            k = rnd[1:0] % 3;
            j = rnd[7:4] % 10;
            for (p = 0; p < 3; p++)
                bus_wr(4'(p), (p == k) ? {27'h0, fn_code[j]} : 32'h0);
            bus_wr(`SIM_REG_POL, {29'h0, rnd[10:8]});
            lvl <= rnd[14:12];
            settle();
            chk("decoded input", 32'(rnd[12 + k] ^ rnd[8 + k]), {31'h0, fo[j]});
        end
        // every select code, mode switch and torque cap
        for (i = 0; i < 8; i++)
        begin
            rnd = lfsr_next(rnd);
            zm = rnd[1] | ~i[0];
            bus_wr(4'h0, 32'h0e);
            bus_wr(4'h1, 32'h0f);
            bus_wr(4'h2, 32'h12);
            bus_wr(`SIM_REG_POL, 32'h0);
            bus_wr(`SIM_REG_CTRL, {30'h0, zm, rnd[0]});
            lvl <= 3'(i);
            settle();
            chk("speed source", 32'(i[1:0]), 32'(spd_src));
            chk("speed zero", 32'(src_zero(i[1:0], zm)), 32'(spd_zero));
            chk("mode", 32'(i[2]), 32'(mode));
            bus_wr(4'h0, 32'h10);
            bus_wr(4'h1, 32'h11);
            bus_wr(4'h2, 32'h19);
            bus_wr(4'h4, 32'h1a);
            bus_wr(4'h5, 32'h13 + 32'(i[0]));
            opn <= {rnd[2], 2'h0};
            settle();
            chk("torque source", 32'(i[1:0]), 32'(trq_src));
            chk("torque zero", 32'(src_zero(i[1:0], zm)), 32'(trq_zero));
            chk("mode switch", 32'(i[0] ? (rnd[2] ? 2 : 1) : (rnd[2] ? 0 : 2)), 32'(mode));
            chk("reverse cap", 32'(i[2] & rnd[0] & (rnd[2] ^ i[0])), 32'(rcap));
            chk("forward cap", 32'(rnd[0] & (rnd[2] ^ i[0])), 32'(fcap));
            bus_wr(4'h4, 32'h17);
            bus_wr(4'h5, 32'h15);
            opn <= 3'h0;
        end
        // output pins from random codes, states and polarity
        for (i = 0; i < 16; i++)
        begin
            rnd = lfsr_next(rnd);
            for (p = 0; p < 3; p++)
            begin
                sel[p] = (rnd[13:10] + p * 3) % 10;
                bus_wr(4'(6 + p), {25'h0, do_code[sel[p]]});
            end
            bus_wr(`SIM_REG_POL, {23'h0, rnd[18:16], 6'h0});
            dev <= rnd[9:0];
            settle();
            for (p = 0; p < 3; p++)
                chk("output pin", 32'(rnd[sel[p]] ^ rnd[16 + p]), 32'(do_pin[p]));
        end
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        bus_rd(4'h0, d);
        chk("code after reset", 32'h1, d);
        end_of_test();
    end
endmodule : test_servo_input_function_mapper
